// file: cc_pkg.sv
// constants, register map and carrier types for the calibration control block
package cc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] CC_IDX_CTRL_ONE = 10'h060;
    localparam logic [9:0] CC_IDX_CTRL_TWO = 10'h061;
    localparam logic [9:0] CC_IDX_RING_RES = 10'h062;
    localparam logic [9:0] CC_IDX_TIP_RES = 10'h063;
    localparam logic [9:0] CC_IDX_DIFF_RES = 10'h064;
    localparam logic [9:0] CC_IDX_CM_RES = 10'h065;
    localparam int CC_ADDR_W = 12;

    // calibration_control_one fields
    localparam int CC_SYS_CAL_BIT = 6;
    localparam int CC_FAST_SETTLE_BIT = 5;
    // routine numbers; pending vector bit n is routine n
    localparam int CC_NUM_CAL = 9;
    localparam int CC_CAL_CURRENT_LIMIT = 0;
    localparam int CC_CAL_CM_GAIN = 1;
    localparam int CC_CAL_DIFF_GAIN = 2;
    localparam int CC_CAL_TIP = 3;
    localparam int CC_CAL_RING = 4;
    localparam int CC_CTRL_ONE_LSB = 0;
    localparam int CC_CTRL_TWO_FIRST = 5;
    localparam int CC_CTRL_TWO_LSB = 1;
    localparam int CC_RES_W = 5;

    // result resets (low five bits of 0x10 and 0x11)
    localparam logic [4:0] CC_RING_RES_RST = 5'h10;
    localparam logic [4:0] CC_TIP_RES_RST = 5'h10;
    localparam logic [4:0] CC_DIFF_RES_RST = 5'h11;
    localparam logic [4:0] CC_CM_RES_RST = 5'h11;

    // battery settling interval
    localparam int unsigned CC_CLK_MHZ = 200;
    localparam int unsigned CC_SETTLE_SLOW_MS = 300;
    localparam int unsigned CC_SETTLE_FAST_MS = 30;
    localparam int unsigned CC_SETTLE_SLOW_CYC = CC_SETTLE_SLOW_MS * 1000 * CC_CLK_MHZ;
    localparam int unsigned CC_SETTLE_FAST_CYC = CC_SETTLE_FAST_MS * 1000 * CC_CLK_MHZ;
    localparam int CC_CNT_W = 26;

    localparam logic [1:0] CC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CC_ST_IDLE = 3'b001,
        CC_ST_SETTLE = 3'b010,
        CC_ST_RUN = 3'b100
    } cc_state_e;

    typedef struct packed {
        logic awvalid;
        logic [CC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [CC_ADDR_W-1:0] araddr;
        logic rready;
    } cc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cc_axi_rsp_s;

    // analog side: one-hot request per routine, done pulse with measured value
    typedef struct packed {
        logic done;
        logic [CC_RES_W-1:0] value;
    } cc_ana_in_s;

    typedef struct packed {
        cc_state_e st;
        logic sys;
        logic fast;
        logic settled;
        logic [CC_NUM_CAL-1:0] pend;
        logic [3:0] cur;
        logic [CC_CNT_W-1:0] cnt;
        logic [3:0][CC_RES_W-1:0] res;
        logic [CC_NUM_CAL-1:0] req;
        logic aw_hold;
        logic [9:0] aw_idx;
        logic w_hold;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } cc_state_s;
endpackage : cc_pkg

// file: cc_calibration_control.sv
// calibration control/status and gain result registers behind an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module cc_calibration_control
    import cc_pkg::*;
#(
    parameter int unsigned SETTLE_SLOW_CYCLES = CC_SETTLE_SLOW_CYC,
    parameter int unsigned SETTLE_FAST_CYCLES = CC_SETTLE_FAST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cc_axi_req_s axi_req,
    output cc_axi_rsp_s axi_rsp,
    input wire cc_ana_in_s ana_in,
    output logic [CC_NUM_CAL-1:0] cal_req,
    output logic sys_cal_busy
);

    cc_state_s s_ff;
    cc_state_s nxt_s;

    localparam logic [CC_CNT_W-1:0] SLOW_LOAD = CC_CNT_W'(SETTLE_SLOW_CYCLES);
    localparam logic [CC_CNT_W-1:0] FAST_LOAD = CC_CNT_W'(SETTLE_FAST_CYCLES);

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx >= CC_IDX_CTRL_ONE && idx <= CC_IDX_CM_RES;
    endfunction : is_mapped

    // result slot of a gain routine: ring 0, tip 1, diff 2, cm 3
    function automatic logic [1:0] res_slot(input logic [3:0] cal);
        case (cal)
            4'(CC_CAL_RING): return 2'h0;
            4'(CC_CAL_TIP): return 2'h1;
            4'(CC_CAL_DIFF_GAIN): return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : res_slot

    function automatic logic [7:0] read_byte(input cc_state_s s, input logic [9:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            CC_IDX_CTRL_ONE: begin
                v[CC_SYS_CAL_BIT] = s.sys;
                v[CC_FAST_SETTLE_BIT] = s.fast;
                v[4:0] = s.pend[4:0];
            end
            CC_IDX_CTRL_TWO: begin
                v[4:1] = s.pend[8:5];
            end
            CC_IDX_RING_RES: v[4:0] = s.res[0];
            CC_IDX_TIP_RES: v[4:0] = s.res[1];
            CC_IDX_DIFF_RES: v[4:0] = s.res[2];
            CC_IDX_CM_RES: v[4:0] = s.res[3];
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    always_comb begin
        logic do_write;
        logic found;
        nxt_s = s_ff;
        do_write = 1'b0;
        found = 1'b0;

        // calibration sequencer: one routine at a time, lowest number first
        case (s_ff.st)
            CC_ST_IDLE: begin
                if (s_ff.sys && !s_ff.settled) begin
                    // battery settles once, before the routines of a full calibration
                    nxt_s.cnt = s_ff.fast ? FAST_LOAD : SLOW_LOAD;
                    nxt_s.st = CC_ST_SETTLE;
                end else if (|s_ff.pend) begin
                    for (int i = 0; i < CC_NUM_CAL; i++) begin
                        if (s_ff.pend[i] && !found) begin
                            found = 1'b1;
                            nxt_s.cur = 4'(i);
                            nxt_s.req = CC_NUM_CAL'(1) << i;
                        end
                    end
                    nxt_s.st = CC_ST_RUN;
                end else if (s_ff.sys) begin
                    nxt_s.sys = 1'b0;
                    nxt_s.settled = 1'b0;
                end
            end
            CC_ST_SETTLE: begin
                if (s_ff.cnt <= CC_CNT_W'(1)) begin
                    nxt_s.settled = 1'b1;
                    nxt_s.st = CC_ST_IDLE;
                end else begin
                    nxt_s.cnt = s_ff.cnt - CC_CNT_W'(1);
                end
            end
            CC_ST_RUN: begin
                if (ana_in.done) begin
                    nxt_s.pend[s_ff.cur] = 1'b0;
                    nxt_s.req = '0;
                    if (s_ff.cur >= 4'(CC_CAL_CM_GAIN) && s_ff.cur <= 4'(CC_CAL_RING)) begin
                        nxt_s.res[res_slot(s_ff.cur)] = ana_in.value;
                    end
                    nxt_s.st = CC_ST_IDLE;
                end
            end
            default: begin
                nxt_s.st = CC_ST_IDLE;
                nxt_s.req = '0;
            end
        endcase

        // write address and data are taken independently, in either order
        if (axi_req.awvalid && s_ff.awready) begin
            nxt_s.aw_hold = 1'b1;
            nxt_s.aw_idx = axi_req.awaddr[CC_ADDR_W-1:2];
        end
        if (axi_req.wvalid && s_ff.wready) begin
            nxt_s.w_hold = 1'b1;
            nxt_s.w_byte = axi_req.wdata[7:0];
            nxt_s.w_lane0 = axi_req.wstrb[0];
        end
        if (s_ff.bvalid && axi_req.bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid) begin
            do_write = is_mapped(s_ff.aw_idx) && s_ff.w_lane0;
            nxt_s.aw_hold = 1'b0;
            nxt_s.w_hold = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = is_mapped(s_ff.aw_idx) ? CC_RESP_OKAY : CC_RESP_SLVERR;
        end
        nxt_s.awready = !nxt_s.aw_hold;
        nxt_s.wready = !nxt_s.w_hold;

        // software writes come after the sequencer: a set beats a same-cycle clear
        if (do_write) begin
            case (s_ff.aw_idx)
                CC_IDX_CTRL_ONE: begin
                    if (s_ff.w_byte[CC_SYS_CAL_BIT]) begin
                        nxt_s.sys = 1'b1;
                        nxt_s.pend = '1;
                    end
                    nxt_s.fast = s_ff.w_byte[CC_FAST_SETTLE_BIT];
                    // writing zero never aborts a routine in progress
                    nxt_s.pend[4:0] = nxt_s.pend[4:0] | s_ff.w_byte[4:0];
                end
                CC_IDX_CTRL_TWO: begin
                    nxt_s.pend[8:5] = nxt_s.pend[8:5] | s_ff.w_byte[4:1];
                end
                CC_IDX_RING_RES: nxt_s.res[0] = s_ff.w_byte[4:0];
                CC_IDX_TIP_RES: nxt_s.res[1] = s_ff.w_byte[4:0];
                CC_IDX_DIFF_RES: nxt_s.res[2] = s_ff.w_byte[4:0];
                CC_IDX_CM_RES: nxt_s.res[3] = s_ff.w_byte[4:0];
                default: nxt_s.bresp = CC_RESP_SLVERR;
            endcase
        end

        // reads see state before any same-cycle write
        if (s_ff.rvalid && axi_req.rready) begin
            nxt_s.rvalid = 1'b0;
            nxt_s.arready = 1'b1;
        end
        if (axi_req.arvalid && s_ff.arready) begin
            nxt_s.arready = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = read_byte(s_ff, axi_req.araddr[CC_ADDR_W-1:2]);
            nxt_s.rresp = is_mapped(axi_req.araddr[CC_ADDR_W-1:2]) ? CC_RESP_OKAY : CC_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
            s_ff.st <= CC_ST_IDLE;
            s_ff.res[0] <= CC_RING_RES_RST;
            s_ff.res[1] <= CC_TIP_RES_RST;
            s_ff.res[2] <= CC_DIFF_RES_RST;
            s_ff.res[3] <= CC_CM_RES_RST;
            s_ff.awready <= 1'b1;
            s_ff.wready <= 1'b1;
            s_ff.arready <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // one driver for the whole response struct; upper read lanes are always zero
    assign axi_rsp = '{
        awready: s_ff.awready,
        wready: s_ff.wready,
        bvalid: s_ff.bvalid,
        bresp: s_ff.bresp,
        arready: s_ff.arready,
        rvalid: s_ff.rvalid,
        rdata: {24'h000000, s_ff.rdata},
        rresp: s_ff.rresp
    };
    assign cal_req = s_ff.req;
    assign sys_cal_busy = s_ff.sys;

endmodule : cc_calibration_control

// file: cc_cal_assertions.sv
// concurrent checks on the calibration control ports
`timescale 1ns/1ps
module cc_cal_assertions
    import cc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire cc_axi_req_s axi_req,
    input wire cc_axi_rsp_s axi_rsp,
    input wire cc_ana_in_s ana_in,
    input wire logic [CC_NUM_CAL-1:0] cal_req,
    input wire logic sys_cal_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_bresp;
        ##2 axi_rsp.bvalid;
    endsequence
    chk_req_one_hot: assert property ($onehot0(cal_req)) else $error("more than one routine requested");
    chk_req_held: assert property (cal_req != 0 && !ana_in.done |=> $stable(cal_req))
        else $error("request changed before done");
    chk_req_drop: assert property (cal_req != 0 && ana_in.done |=> cal_req == 0)
        else $error("request stayed after done");
    chk_sys_end: assert property ($fell(sys_cal_busy) |-> cal_req == 0)
        else $error("system busy cleared with a routine open");
    chk_wr_answer: assert property (s_wr_take |-> s_bresp)
        else $error("write response late");
    chk_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read data late");
    chk_b_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response not released");
    chk_rdata_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule : cc_cal_assertions

bind cc_calibration_control cc_cal_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .ana_in(ana_in), .cal_req(cal_req), .sys_cal_busy(sys_cal_busy));

// file: tb_top.sv
// register-level bench for the calibration control block
`timescale 1ns/1ps
module tb_top
    import cc_pkg::*;
;
    logic aclk;
    logic aresetn;
    cc_axi_req_s axi_req;
    cc_axi_rsp_s axi_rsp;
    cc_ana_in_s ana_in;
    logic [CC_NUM_CAL-1:0] cal_req;
    logic sys_cal_busy;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int t;
    logic [1:0] r;
    logic [9:0] ix;
    logic [7:0] b;

    cc_calibration_control #(.SETTLE_SLOW_CYCLES(20), .SETTLE_FAST_CYCLES(5)) DUT (.aclk(aclk),
        .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .ana_in(ana_in), .cal_req(cal_req),
        .sys_cal_busy(sys_cal_busy));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= {i, 2'b00};
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {24'h0, d};
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while ((axi_req.awvalid && !axi_rsp.awready) || (axi_req.wvalid && !axi_rsp.wready));
        do @(posedge aclk); while (!axi_rsp.bvalid);
        axi_req.bready <= 1'b0;
        r = axi_rsp.bresp;
    endtask : wr

    task automatic rc(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= {i, 2'b00};
        axi_req.rready <= 1'b1;
        do @(posedge aclk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        do @(posedge aclk); while (!axi_rsp.rvalid);
        axi_req.rready <= 1'b0;
        chk(axi_rsp.rdata, {24'h0, e});
        chk({30'h0, axi_rsp.rresp}, {30'h0, er});
    endtask : rc

    // extra edge after done so the dropped request is seen before the next wait
    task automatic srv(input int n, input logic [4:0] v);
        while (cal_req === 9'h0) @(posedge aclk);
        chk({23'h0, cal_req}, 32'h1 << n);
        ana_in <= '{done: 1'b1, value: v};
        @(posedge aclk);
        ana_in.done <= 1'b0;
        @(posedge aclk);
    endtask : srv

    initial begin
        aresetn = 1'b0;
        axi_req = '0;
        ana_in = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 6; k++) rc(10'h060 + k, k < 2 ? 8'h00 : (k < 4 ? 8'h10 : 8'h11), CC_RESP_OKAY);
        for (int k = 2; k < 6; k++) begin
            wr(10'h060 + k, 8'hff);
            chk({30'h0, r}, {30'h0, CC_RESP_OKAY});
            rc(10'h060 + k, 8'h1f, CC_RESP_OKAY);
        end
        wr(CC_IDX_CTRL_TWO, 8'he1);
        rc(CC_IDX_CTRL_TWO, 8'h00, CC_RESP_OKAY);
        wr(CC_IDX_CTRL_ONE, 8'h80);
        rc(CC_IDX_CTRL_ONE, 8'h00, CC_RESP_OKAY);
        wr(10'h066, 8'h01);
        chk({30'h0, r}, {30'h0, CC_RESP_SLVERR});
        rc(10'h066, 8'h00, CC_RESP_SLVERR);
        for (int n = 0; n < CC_NUM_CAL; n++) begin
            ix = n < 5 ? CC_IDX_CTRL_ONE : CC_IDX_CTRL_TWO;
            b = 8'h01 << (n < 5 ? n : n - 4);
            wr(ix, b);
            rc(ix, b, CC_RESP_OKAY);
            srv(n, 5'(n + 9));
            rc(ix, 8'h00, CC_RESP_OKAY);
            if (n > 0 && n < 5) rc(10'h066 - n, 8'(n + 9), CC_RESP_OKAY);
        end
        for (int f = 1; f >= 0; f--) begin
            wr(CC_IDX_CTRL_ONE, f ? 8'h60 : 8'h40);
            rc(CC_IDX_CTRL_ONE, f ? 8'h7f : 8'h5f, CC_RESP_OKAY);
            chk({31'h0, sys_cal_busy}, 32'h1);
            t = 0;
            while (cal_req === 9'h0) begin
                @(posedge aclk);
                t++;
            end
            chk({31'h0, t < 12}, f);
            for (int k = 0; k < CC_NUM_CAL; k++) srv(k, 5'(k + 2));
            rc(CC_IDX_CTRL_ONE, f ? 8'h20 : 8'h00, CC_RESP_OKAY);
            rc(CC_IDX_RING_RES, 8'h06, CC_RESP_OKAY);
        end
        report_and_stop();
    end
endmodule : tb_top
